/* bench/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
  import tcp_pkg::*;
  // Clock and synchronous reset.
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  // Master side of the register bus.
  logic [7:0] awAddr = 8'h00;
  logic awValid = 1'b0;
  logic [31:0] wData = 32'h0;
  logic [3:0] wStrb = 4'hf;
  logic wValid = 1'b0;
  logic bReady = 1'b0;
  logic [7:0] arAddr = 8'h00;
  logic arValid = 1'b0;
  logic rReady = 1'b0;
  // Slave answers.
  logic awReady, wReady, bValid, arReady, rValid;
  logic [1:0] bResp, rResp;
  logic [31:0] rData;
  // Port levels in and pin levels out.
  logic [1:0] portData = 2'b00;
  logic [1:0] pinOut, pinOe;
  // Counters and the last bus answer.
  int mismatches = 0;
  int n_checks = 0;
  logic [1:0] resp;
  logic [31:0] data;

  // The clock toggles every half period of 4 ns.
  always #4 clk = ~clk;

  tcp_timer dut (
    .clk(clk), .sys_rst(sys_rst),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid),
    .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
    .s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
    .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
    .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .portData(portData), .pinOut(pinOut), .pinOe(pinOe)
  );

  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // A wait that ran out counts as a mismatch and closes the run.
  task automatic hang(input string what);
    mismatches++;
    $display("FAIL %0t timeout in %s", $time, what);
    tally_and_finish();
  endtask

  // Compares a register or pin value.
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Compares a measured count of cycles or edges.
  task automatic chk_cnt(input int got, input int exp, input string what);
    n_checks++;
    if (got != exp) begin
      mismatches++;
      $display("FAIL %0t %s got %0d exp %0d", $time, what, got, exp);
    end
  endtask

  // One write; address and data are held until each is taken.
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    awAddr <= a;
    wData <= d;
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= 1'b1;
    while (n < 50) begin
      @(posedge clk);
      if (awReady === 1'b1)
        awValid <= 1'b0;
      if (wReady === 1'b1)
        wValid <= 1'b0;
      if (bValid === 1'b1) begin
        resp = bResp;
        bReady <= 1'b0;
        return;
      end
      n++;
    end
    hang("write");
  endtask

  // One read; the answer is taken at the edge where rvalid is seen.
  task automatic axi_read(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge clk);
    arAddr <= a;
    arValid <= 1'b1;
    rReady <= 1'b1;
    while (n < 50) begin
      @(posedge clk);
      if (arReady === 1'b1)
        arValid <= 1'b0;
      if (rValid === 1'b1) begin
        data = rData;
        resp = rResp;
        rReady <= 1'b0;
        return;
      end
      n++;
    end
    hang("read");
  endtask

  // Packs a control word through the package's bundle layout.
  function automatic logic [31:0] ctrlWord(input logic [3:0] m, input logic [1:0] ca,
                                           input logic [1:0] cb, input logic [2:0] pre,
                                           input logic da, input logic db);
    tcp_ctrl_s cw;
    cw = '{dirB: db, dirA: da, preSel: pre, comB: cb, comA: ca, mode: m};
    return {19'h0, cw};
  endfunction

  // Compare A goes first so that a buffered value has loaded before the mode changes.
  task automatic setup(input logic [31:0] c, input logic [31:0] a, input logic [31:0] b,
                       input logic [31:0] t);
    axi_write(ADDR_CMPA, a);
    axi_write(ADDR_CAPT, t);
    axi_write(ADDR_CMPB, b);
    axi_write(ADDR_CTRL, c);
    axi_write(ADDR_COUNT, 32'h0);
  endtask

  // Counts edges and high cycles of one pin over a window.
  task automatic measure(input int idx, input int len, output int edges, output int highs);
    logic prev;
    edges = 0;
    highs = 0;
    prev = pinOut[idx];
    repeat (len) begin
      @(posedge clk);
      if (pinOut[idx] !== prev)
        edges++;
      if (pinOut[idx] === 1'b1)
        highs++;
      prev = pinOut[idx];
    end
  endtask

  // Clears all flags, lets the timer run, then reads them back.
  task automatic flags_after(input int n);
    axi_write(ADDR_FLAGS, 32'hf);
    repeat (n) @(posedge clk);
    axi_read(ADDR_FLAGS);
  endtask

  // Reset values and refusal of an unmapped address.
  task automatic sc_reset();
    chk_word({30'h0, pinOut}, 32'h0, "pins after reset");
    chk_word({30'h0, pinOe}, 32'h0, "enables after reset");
    axi_read(ADDR_CTRL);
    chk_word(data, CTRL_RESET, "ctrl reset");
    axi_read(ADDR_FLAGS);
    chk_word(data, 32'h0, "flags reset");
    axi_read(8'h18);
    chk_word({resp, data[29:0]}, {2'b10, 30'h0}, "unmapped read");
    axi_write(8'h1c, 32'hffff_ffff);
    chk_word({30'h0, resp}, 32'h2, "unmapped write");
  endtask

  // Clear-on-match toggle at every prescaler setting, slowest first.
  task automatic sc_ctc_prescale();
    int e, h, iv;
    int divs[5] = '{1, 8, 64, 256, 1024};
    for (int p = 4; p >= 0; p--) begin
      iv = 4 * divs[p];
      setup(ctrlWord(MODE_CTC_A, COM_TOGGLE, COM_OFF, 3'(p), 1'b1, 1'b0), 32'h3, 32'h0, 32'h0);
      repeat (2 * iv) @(posedge clk);
      measure(0, 4 * iv, e, h);
      chk_cnt(e, 4, "ctc toggle edges");
    end
    flags_after(20);
    chk_word(data & 32'h3, 32'h2, "ctc compare flag");
  endtask

  // Clear-on-match with the capture register as top.
  task automatic sc_ctc_capt();
    int e, h;
    setup(ctrlWord(MODE_CTC_CAPT, COM_TOGGLE, COM_OFF, 3'h0, 1'b1, 1'b0), 32'h2, 32'h0, 32'h5);
    repeat (20) @(posedge clk);
    measure(0, 60, e, h);
    chk_cnt(e, 10, "capture top edges");
    flags_after(20);
    chk_word(data & 32'h9, 32'h8, "capture top flag");
  endtask

  // Counter above top runs to the maximum and wraps before matching.
  task automatic sc_wrap();
    setup(ctrlWord(MODE_CTC_A, COM_OFF, COM_OFF, 3'h0, 1'b0, 1'b0), 32'h10, 32'h0, 32'h0);
    axi_write(ADDR_COUNT, 32'hfff0);
    flags_after(0);
    chk_word(data & 32'h3, 32'h0, "no match above top");
    repeat (40) @(posedge clk);
    axi_read(ADDR_FLAGS);
    chk_word(data & 32'h3, 32'h3, "wrap then match");
  endtask

  // Fast PWM on channel B with capture top, both polarities.
  task automatic sc_pwm_b();
    int e, h;
    setup(ctrlWord(MODE_FPWM_CAPT, COM_OFF, COM_NONINV, 3'h0, 1'b0, 1'b1),
          32'h4, 32'h3, 32'h9);
    repeat (20) @(posedge clk);
    measure(1, 100, e, h);
    chk_cnt(h, 60, "noninverting high");
    chk_word({30'h0, pinOe}, 32'h2, "only B driven");
    axi_write(ADDR_CTRL, ctrlWord(MODE_FPWM_CAPT, COM_OFF, COM_INV, 3'h0, 1'b0, 1'b1));
    repeat (20) @(posedge clk);
    measure(1, 100, e, h);
    chk_cnt(h, 40, "inverting high");
    flags_after(20);
    chk_word(data, 32'hf, "capture top flags");
    // Extreme compare values: equal to top holds high, zero leaves a one-cycle low spike.
    axi_write(ADDR_CTRL, ctrlWord(MODE_FPWM_CAPT, COM_OFF, COM_NONINV, 3'h0, 1'b0, 1'b1));
    axi_write(ADDR_CMPB, 32'h9);
    repeat (20) @(posedge clk);
    measure(1, 100, e, h);
    chk_cnt(h, 100, "compare at top level");
    axi_write(ADDR_CMPB, 32'h0);
    repeat (20) @(posedge clk);
    measure(1, 100, e, h);
    chk_cnt(h, 90, "compare zero spike");
  endtask

  // Mode 15 toggle and the buffered compare A.
  task automatic sc_pwm_a();
    int e, h;
    setup(ctrlWord(MODE_FPWM_A, COM_TOGGLE, COM_OFF, 3'h0, 1'b1, 1'b0),
          32'h4, 32'h3, 32'h9);
    repeat (20) @(posedge clk);
    measure(0, 80, e, h);
    chk_cnt(e, 16, "mode 15 toggle");
    flags_after(20);
    chk_word(data, 32'h7, "compare A top flags");
    axi_write(ADDR_CMPA, 32'h9);
    repeat (30) @(posedge clk);
    measure(0, 80, e, h);
    chk_cnt(e, 8, "new top after load");
  endtask

  // Fixed tops mask compare bits above the resolution.
  task automatic sc_mask();
    logic [3:0] modes[3] = '{MODE_FPWM8, MODE_FPWM9, MODE_FPWM10};
    logic [15:0] tops[3] = '{TOP_8BIT, TOP_9BIT, TOP_10BIT};
    for (int i = 0; i < 3; i++) begin
      axi_write(ADDR_CTRL, ctrlWord(modes[i], COM_OFF, COM_OFF, 3'h0, 1'b0, 1'b0));
      axi_write(ADDR_CMPB, 32'hf3a5);
      axi_read(ADDR_CMPB);
      chk_word(data, 32'hf3a5 & {16'h0, tops[i]}, "masked compare");
    end
  endtask

  // Port levels pass when output mode is off; direction bits gate drive.
  task automatic sc_port();
    axi_write(ADDR_CTRL, ctrlWord(MODE_CTC_A, COM_OFF, COM_OFF, 3'h0, 1'b1, 1'b1));
    portData <= 2'b01;
    repeat (4) @(posedge clk);
    chk_word({30'h0, pinOut}, 32'h1, "port level A");
    chk_word({30'h0, pinOe}, 32'h3, "both driven");
    portData <= 2'b10;
    axi_write(ADDR_CTRL, ctrlWord(MODE_CTC_A, COM_OFF, COM_OFF, 3'h0, 1'b0, 1'b0));
    repeat (4) @(posedge clk);
    chk_word({30'h0, pinOut}, 32'h2, "port level B");
    chk_word({30'h0, pinOe}, 32'h0, "none driven");
  endtask

  // Reset for 16 cycles, then every scenario in turn.
  initial begin
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    sc_reset();
    sc_ctc_prescale();
    sc_ctc_capt();
    sc_wrap();
    sc_pwm_b();
    sc_pwm_a();
    sc_mask();
    sc_port();
    tally_and_finish();
  end
endmodule // tb_top

/* logic/tcp_pkg.sv */
package tcp_pkg;
  // Register byte offsets on the AXI4-Lite bus.
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_COUNT = 8'h04;
  localparam logic [7:0] ADDR_CMPA = 8'h08;
  localparam logic [7:0] ADDR_CMPB = 8'h0c;
  localparam logic [7:0] ADDR_CAPT = 8'h10;
  localparam logic [7:0] ADDR_FLAGS = 8'h14;
  // Control word field positions.
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_COMA_LSB = 4;
  localparam int CTRL_COMB_LSB = 6;
  localparam int CTRL_PRE_LSB = 8;
  localparam int CTRL_DIRA_BIT = 11;
  localparam int CTRL_DIRB_BIT = 12;
  // Flag bit positions.
  localparam int FLG_OVF = 0;
  localparam int FLG_CMPA = 1;
  localparam int FLG_CMPB = 2;
  localparam int FLG_CAPT = 3;
  // Waveform mode codes that this block honours.
  localparam logic [3:0] MODE_CTC_A = 4'h4;
  localparam logic [3:0] MODE_FPWM8 = 4'h5;
  localparam logic [3:0] MODE_FPWM9 = 4'h6;
  localparam logic [3:0] MODE_FPWM10 = 4'h7;
  localparam logic [3:0] MODE_CTC_CAPT = 4'hc;
  localparam logic [3:0] MODE_FPWM_CAPT = 4'he;
  localparam logic [3:0] MODE_FPWM_A = 4'hf;
  // Fixed tops and the counter maximum.
  localparam logic [15:0] TOP_8BIT = 16'h00ff;
  localparam logic [15:0] TOP_9BIT = 16'h01ff;
  localparam logic [15:0] TOP_10BIT = 16'h03ff;
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  localparam logic [15:0] COUNT_BOTTOM = 16'h0000;
  // Output mode encodings.
  localparam logic [1:0] COM_OFF = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_NONINV = 2'h2;
  localparam logic [1:0] COM_INV = 2'h3;
  // Prescaler terminal counts minus one (divide by 1, 8, 64, 256, 1024).
  localparam logic [9:0] PRE_DIV8 = 10'h007;
  localparam logic [9:0] PRE_DIV64 = 10'h03f;
  localparam logic [9:0] PRE_DIV256 = 10'h0ff;
  localparam logic [9:0] PRE_DIV1024 = 10'h3ff;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // Decoded control word carried as one bundle.
  typedef struct packed {
    logic dirB;
    logic dirA;
    logic [2:0] preSel;
    logic [1:0] comB;
    logic [1:0] comA;
    logic [3:0] mode;
  } tcp_ctrl_s;
endpackage

/* logic/tcp_timer.sv */
// What this block does
// - Clear-on-match mode clears counter at A/capture match.
// - Clear-on-match sets A or capture flag at top.
// - Unbuffered top below count runs to maximum first.
// - Clear-on-match output mode 1 toggles output A.
// - Pin driven only while its direction bit set.
// - Clear-on-match overflow flag set on max-to-zero roll.
// - Fast PWM modes count up, bottom to top.
// - Mode 2 set-on-match clear-at-top; mode 3 inverse.
// - Fast PWM top: fixed, capture or A; clear next.
// - Fast PWM flags set on each compare equality.
// - Fast PWM overflow at top, plus top register flag.
// - Fixed top masks high compare bits on write.
// - Capture top takes effect at once, unbuffered.
// - Fast PWM compare A buffered, loaded at top.
// - Compare zero spikes; compare top gives constant level.
// - Mode 15 output mode 1 toggles output A.
// - Counter advances per prescaled timer clock.
// - Counter write blocks matches next timer cycle.
// - Output mode 0 leaves state; nonzero overrides port.
// - Reset clears internal compare output states.
// - Output mode changes act at next match or top; port override switches next clock.
//
// The register offsets and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ns
module tcp_timer
  import tcp_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] portData,
  output logic [1:0] pinOut,
  output logic [1:0] pinOe
);

  // Word with byte enables merged over an old value.
  function automatic logic [31:0] mergeBytes(input logic [31:0] oldV, input logic [31:0] newV,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = oldV;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = newV[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Mask a compare value to the active fixed resolution.
  function automatic logic [15:0] maskFixed(input logic [3:0] mode, input logic [15:0] v);
    case (mode)
      MODE_FPWM8: maskFixed = v & TOP_8BIT;
      MODE_FPWM9: maskFixed = v & TOP_9BIT;
      MODE_FPWM10: maskFixed = v & TOP_10BIT;
      default: maskFixed = v;
    endcase
  endfunction

  // Register state.
  logic [31:0] ctrl_r; // Control word.
  tcp_ctrl_s cfg; // Decoded control fields.
  logic [15:0] count_r; // Counter.
  logic [15:0] cmpA_r; // Active compare A value.
  logic [15:0] cmpABuf_r; // Compare A buffer written by software.
  logic [15:0] cmpB_r; // Compare B value.
  logic [15:0] capt_r; // Capture value, also a top source.
  logic [3:0] flags_r; // Sticky event flags.
  logic [1:0] ocState_r; // Internal compare output states.
  logic [9:0] preCnt_r; // Prescaler counter.
  logic blockNext_r; // Counter was written; block next tick's matches.
  // Bus handshake state.
  logic awHeld_r;
  logic wHeld_r;
  logic [7:0] awAddr_r;
  logic [31:0] wData_r;
  logic [3:0] wStrb_r;

  assign cfg = tcp_ctrl_s'(ctrl_r[12:0]);

  // Mode decode.
  logic isCtc;
  logic isFpwm;
  logic [15:0] topVal;
  logic tick;
  logic atTop;
  logic matchA;
  logic matchB;
  logic wrFire;
  logic wrCount;
  logic wrCmpA;
  logic wrCmpB;
  logic wrCapt;
  logic wrFlags;
  logic wrCtrl;
  logic [31:0] wWord;
  logic [9:0] preLimit;

  assign isCtc = (cfg.mode == MODE_CTC_A) || (cfg.mode == MODE_CTC_CAPT);
  assign isFpwm = (cfg.mode == MODE_FPWM8) || (cfg.mode == MODE_FPWM9) ||
                  (cfg.mode == MODE_FPWM10) || (cfg.mode == MODE_FPWM_CAPT) ||
                  (cfg.mode == MODE_FPWM_A);

  // Top selection per mode; capture is used live, unbuffered.
  always_comb begin
    case (cfg.mode)
      MODE_CTC_A: topVal = cmpA_r;
      MODE_CTC_CAPT: topVal = capt_r;
      MODE_FPWM8: topVal = TOP_8BIT;
      MODE_FPWM9: topVal = TOP_9BIT;
      MODE_FPWM10: topVal = TOP_10BIT;
      MODE_FPWM_CAPT: topVal = capt_r;
      MODE_FPWM_A: topVal = cmpA_r;
      default: topVal = COUNT_MAX;
    endcase
  end

  // Prescaler terminal count selection.
  always_comb begin
    case (cfg.preSel)
      3'h1: preLimit = PRE_DIV8;
      3'h2: preLimit = PRE_DIV64;
      3'h3: preLimit = PRE_DIV256;
      3'h4: preLimit = PRE_DIV1024;
      default: preLimit = 10'h000;
    endcase
  end

  assign tick = (preCnt_r >= preLimit);
  // Equality only; a top below the count is simply missed until wrap.
  assign atTop = (isCtc || isFpwm) && (count_r == topVal);
  assign matchA = (count_r == cmpA_r) && !blockNext_r;
  assign matchB = (count_r == cmpB_r) && !blockNext_r;

  // Write decode once both address and data are held.
  assign wrFire = awHeld_r && wHeld_r && !s_axi_bvalid;
  assign wWord = wData_r;
  assign wrCtrl = wrFire && (awAddr_r == ADDR_CTRL);
  assign wrCount = wrFire && (awAddr_r == ADDR_COUNT);
  assign wrCmpA = wrFire && (awAddr_r == ADDR_CMPA);
  assign wrCmpB = wrFire && (awAddr_r == ADDR_CMPB);
  assign wrCapt = wrFire && (awAddr_r == ADDR_CAPT);
  assign wrFlags = wrFire && (awAddr_r == ADDR_FLAGS);

  // Prescaler: free-running divide, restarts at each tick.
  always_ff @(posedge clk) begin
    if (sys_rst || tick) begin
      preCnt_r <= 10'h000;
    end else begin
      preCnt_r <= preCnt_r + 10'h001;
    end
  end

  // Match blocking: armed by a counter write, cleared by the next tick.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      blockNext_r <= 1'b0;
    end else if (wrCount) begin
      blockNext_r <= 1'b1;
    end else if (tick) begin
      blockNext_r <= 1'b0;
    end
  end

  // Counter value with the written bytes merged in; only the low half is kept.
  logic [31:0] countMerged;
  assign countMerged = mergeBytes({16'h0000, count_r}, wWord, wStrb_r);

  // Counter: clears after top, otherwise counts up and wraps at maximum.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      count_r <= COUNT_BOTTOM;
    end else if (wrCount) begin
      count_r <= countMerged[15:0];
    end else if (tick) begin
      if (atTop && !blockNext_r) begin
        count_r <= COUNT_BOTTOM;
      end else begin
        count_r <= count_r + 16'h0001;
      end
    end
  end

  // Compare registers, capture register and the A buffer.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cmpA_r <= COUNT_BOTTOM;
      cmpABuf_r <= COUNT_BOTTOM;
      cmpB_r <= COUNT_BOTTOM;
      capt_r <= COUNT_BOTTOM;
    end else begin
      if (wrCmpA) begin
        cmpABuf_r <= maskFixed(cfg.mode, wWord[15:0]);
        if (!isFpwm) begin
          cmpA_r <= maskFixed(cfg.mode, wWord[15:0]);
        end
      end else if (isFpwm && tick && atTop && !blockNext_r) begin
        cmpA_r <= cmpABuf_r;
      end
      if (wrCmpB) begin
        cmpB_r <= maskFixed(cfg.mode, wWord[15:0]);
      end
      if (wrCapt) begin
        capt_r <= wWord[15:0];
      end
    end
  end

  // Control word.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_r <= CTRL_RESET;
    end else if (wrCtrl) begin
      ctrl_r <= mergeBytes(ctrl_r, wWord, wStrb_r) & 32'h0000_1fff;
    end
  end

  // Event flags: set wins over a write-one-to-clear in the same cycle.
  logic [3:0] flagSet;
  always_comb begin
    flagSet = 4'h0;
    if (tick) begin
      if (isCtc) begin
        flagSet[FLG_OVF] = (count_r == COUNT_MAX);
        flagSet[FLG_CMPA] = matchA;
        flagSet[FLG_CMPB] = matchB;
        flagSet[FLG_CAPT] = (cfg.mode == MODE_CTC_CAPT) && atTop && !blockNext_r;
      end else if (isFpwm) begin
        flagSet[FLG_OVF] = atTop && !blockNext_r;
        flagSet[FLG_CMPA] = matchA;
        flagSet[FLG_CMPB] = matchB;
        flagSet[FLG_CAPT] = (cfg.mode == MODE_FPWM_CAPT) && atTop && !blockNext_r;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      flags_r <= 4'h0;
    end else if (wrFlags && wStrb_r[0]) begin
      flags_r <= (flags_r & ~wWord[3:0]) | flagSet;
    end else begin
      flags_r <= flags_r | flagSet;
    end
  end

  // Per-channel output mode and match, channel A at index 0; mode bits are live.
  logic [1:0][1:0] chCom;
  logic [1:0] chMatch;
  assign chCom = {cfg.comB, cfg.comA};
  assign chMatch = {matchB, matchA};

  // Compare output waveform per channel; mode bits read live at the match.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ocState_r <= 2'b00;
    end else if (tick) begin
      for (int c = 0; c < 2; c++) begin
        if (isCtc) begin
          if (chMatch[c] && chCom[c] == COM_TOGGLE && c == 0) begin
            ocState_r[c] <= ~ocState_r[c];
          end
        end else if (isFpwm) begin
          if (chCom[c] == COM_TOGGLE) begin
            if (c == 0 && cfg.mode == MODE_FPWM_A && chMatch[c]) begin
              ocState_r[c] <= ~ocState_r[c];
            end
          end else if (chCom[c] == COM_NONINV || chCom[c] == COM_INV) begin
            // Match wins over top so compare equal to top holds a level.
            if (chMatch[c]) begin
              ocState_r[c] <= (chCom[c] == COM_NONINV);
            end else if (atTop && !blockNext_r) begin
              ocState_r[c] <= (chCom[c] == COM_INV);
            end
          end // Mode 0: no action.
        end
      end
    end
  end

  // Pin drive: compare state overrides port data when mode is nonzero.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pinOut <= 2'b00;
      pinOe <= 2'b00;
    end else begin
      pinOut[0] <= (cfg.comA != COM_OFF) ? ocState_r[0] : portData[0];
      pinOut[1] <= (cfg.comB != COM_OFF) ? ocState_r[1] : portData[1];
      pinOe <= {cfg.dirB, cfg.dirA};
    end
  end

  // AXI4-Lite write channels: take address and data in either order.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      awAddr_r <= 8'h00;
      wData_r <= 32'h0000_0000;
      wStrb_r <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else begin
      s_axi_awready <= !awHeld_r && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !wHeld_r && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_r <= 1'b1;
        awAddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_r <= 1'b1;
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
      end
      if (wrFire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awAddr_r[1:0] == 2'b00 && awAddr_r <= ADDR_FLAGS) ? 2'b00 : 2'b10;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        awHeld_r <= 1'b0;
        wHeld_r <= 1'b0;
      end
    end
  end

  // AXI4-Lite read channel: one cycle to accept, data the next.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'b00;
        case (s_axi_araddr)
          ADDR_CTRL: s_axi_rdata <= ctrl_r;
          ADDR_COUNT: s_axi_rdata <= {16'h0000, count_r};
          ADDR_CMPA: s_axi_rdata <= {16'h0000, isFpwm ? cmpABuf_r : cmpA_r};
          ADDR_CMPB: s_axi_rdata <= {16'h0000, cmpB_r};
          ADDR_CAPT: s_axi_rdata <= {16'h0000, capt_r};
          ADDR_FLAGS: s_axi_rdata <= {28'h0000000, flags_r};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b10;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Fast PWM wrap: counter at top on a free tick clears next cycle.
  property p_wrap;
    @(posedge clk) disable iff (sys_rst)
    (tick && isFpwm && atTop && !blockNext_r && !wrCount) |=> (count_r == COUNT_BOTTOM);
  endproperty
  a_wrap: assert property (p_wrap) else $error("counter did not clear after top");

  property p_ovf;
    @(posedge clk) disable iff (sys_rst)
    (tick && isFpwm && atTop && !blockNext_r) |=> flags_r[FLG_OVF];
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow flag missing at top");

  property p_block;
    @(posedge clk) disable iff (sys_rst)
    (wrCount && !tick) |=> (!matchA && !matchB);
  endproperty
  a_block: assert property (p_block) else $error("match not blocked after count write");

  property p_oe;
    @(posedge clk) disable iff (sys_rst)
    ##1 (pinOe == {$past(cfg.dirB), $past(cfg.dirA)});
  endproperty
  a_oe: assert property (p_oe) else $error("pin enable disagrees with direction");

  property p_load;
    @(posedge clk) disable iff (sys_rst)
    (tick && isFpwm && atTop && !blockNext_r && !wrCmpA) |=> (cmpA_r == $past(cmpABuf_r));
  endproperty
  a_load: assert property (p_load) else $error("compare A not loaded at top");

  property p_ctcToggle;
    @(posedge clk) disable iff (sys_rst)
    (tick && isCtc && matchA && cfg.comA == COM_TOGGLE) |=> (ocState_r[0] != $past(ocState_r[0]));
  endproperty
  a_ctcToggle: assert property (p_ctcToggle) else $error("output A did not toggle");

  property p_ctcOvf;
    @(posedge clk) disable iff (sys_rst)
    (tick && isCtc && count_r == COUNT_MAX) |=> flags_r[FLG_OVF];
  endproperty
  a_ctcOvf: assert property (p_ctcOvf) else $error("overflow flag missing on roll");

  property p_nonInv;
    @(posedge clk) disable iff (sys_rst)
    (tick && isFpwm && matchA && cfg.comA == COM_NONINV) |=> ocState_r[0];
  endproperty
  a_nonInv: assert property (p_nonInv) else $error("output A not set at match");

endmodule // tcp_timer
